/* msd_defines.svh */
// Constants of the memory space decoder: bus offsets, field positions,
// reset values and address ranges.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// Register byte offsets on the APB slave
`define MSD_OFF_PTR_CFG   8'h00
`define MSD_OFF_MEM_CTL   8'h04
`define MSD_OFF_PAGE      8'h08
`define MSD_OFF_STATUS    8'h0c
`define MSD_OFF_SIG_PTR   8'h10
`define MSD_OFF_SIG_DATA  8'h14

// Field positions
`define MSD_SIG_SEL_BIT   3
`define MSD_IAP_BIT       7
`define MSD_FDE_BIT       3
`define MSD_PAGE_BIT      0

// Reset values
`define MSD_PTR_CFG_RST   8'h00
`define MSD_MEM_CTL_RST   8'h00
`define MSD_PAGE_RST      1'h0
`define MSD_SIG_PTR_RST   8'h00

// Address ranges
`define MSD_XRAM_TOP      16'h01ff
`define MSD_FLASH_DATA_SPACE_TOP_4K  16'h03ff
`define MSD_FLASH_DATA_SPACE_TOP_8K  16'h05ff
`define MSD_CODE_TOP_4K   16'h0fff
`define MSD_CODE_TOP_8K   16'h1fff
`define MSD_SIG_TOP       16'h00ff
`define MSD_FACT_TOP      8'h3f
`define MSD_USER_BASE     8'h80
`define MSD_CAL_PAGE      8'hc0
`define MSD_VECTOR_SPAN   16'h0053
`define MSD_SIG_DEPTH     256

`endif

/* msd_pkg.sv */
// Types of the memory space decoder.
// Assumes nothing beyond the constants header.
package msd_pkg;

   // Kind of access issued by the CPU core
   typedef enum logic [2:0]
   {
      K_FETCH     = 3'h0,
      K_CODE_RD   = 3'h1,
      K_DIRECT    = 3'h2,
      K_INDIRECT  = 3'h3,
      K_XMOVE_RI  = 3'h4,
      K_XMOVE_PTR = 3'h5
   } msd_kind_type;

   // One-hot target store
   typedef enum logic [7:0]
   {
      T_NONE  = 8'h01,
      T_DRAM  = 8'h02,
      T_IRAM  = 8'h04,
      T_SFR   = 8'h08,
      T_XRAM  = 8'h10,
      T_FLASH_DATA_SPACE = 8'h20,
      T_CODE  = 8'h40,
      T_SIG   = 8'h80
   } msd_target_type;

   // APB answer sequencer
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'h1,
      ST_SIGRD = 3'h2,
      ST_ANS   = 3'h4
   } msd_state_type;

endpackage

/* msd_sig_mem.sv */
// Signature array store: factory page low, user pages high.
// Assumes one requester per cycle; arbitration is done by the caller.
`timescale 1ns/1ns
`include "msd_defines.svh"

module msd_sig_mem
   import msd_pkg::*;
#(
   parameter int         DEPTH   = `MSD_SIG_DEPTH,
   parameter logic [7:0] ID_BYTE0 = 8'h5a,  // Arbitrary identification value
   parameter logic [7:0] ID_BYTE1 = 8'h3c,  // Arbitrary identification value
   parameter logic [7:0] CAL_BYTE = 8'h80
)
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       en,
   input  wire logic       we,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata_q
);

   logic [7:0] mem_q [DEPTH];

   // Preload image: identity in the factory page, calibration in the upper user page
   function automatic logic [7:0] init_byte(input int idx);
      logic [7:0] v;
      v = 8'hff;
      if (idx == 0)
      begin
         v = ID_BYTE0;
      end
      else if (idx == 1)
      begin
         v = ID_BYTE1;
      end
      else if (idx == int'(`MSD_CAL_PAGE))
      begin
         v = CAL_BYTE;
      end
      return v;
   endfunction

   // Array contents; reset restores the preload as a nonvolatile stand-in
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= init_byte(i);  // [RL13] [RL14]
         end
      end
      else if (en && we)
      begin
         mem_q[addr] <= wdata;
      end
   end

   // Registered read port
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 8'h00;
      end
      else if (en && !we)
      begin
         rdata_q <= mem_q[addr];
      end
   end

endmodule

/* msd_decoder.sv */
// Memory space decoder: steers CPU accesses to on-chip stores, APB registers.
// Assumes a CPU core on clk issuing at most one access per cycle.
//
// Notes on behaviour
// RL1 - Code and data spaces stay separate, linear
// RL2 - Direct 00-7F reaches lower RAM
// RL3 - Indirect 00-FF reaches full RAM, stack
// RL4 - Direct 80-FF reaches special registers
// RL5 - External moves: extra RAM, then flash data
// RL6 - Code reaches flash program, 4K or 8K
// RL7 - No off-chip path; misses go nowhere
// RL8 - Vectors lie in lowest 83 code bytes
// RL9 - Code reads cover whole program space
// RL10 - Signature select redirects code reads
// RL11 - User array 80-FF, factory 00-3F
// RL12 - Programming plus select lets moves write signature
// RL13 - 128-byte user, 64-byte factory arrays
// RL14 - Upper user page holds calibration data
// RL15 - Security lock blocks signature writes only
// RL16 - Signature space spans 0000-00FF alone
// RL17 - Pointer moves reach extra RAM without programming
// RL18 - Flash data decoded only when enabled
// RL19 - Page bit picks extra RAM half
// RL20 - Unmapped moves ignored, harmless read
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
`include "msd_defines.svh"

module msd_decoder
   import msd_pkg::*;
#(
   parameter bit         VARIANT_8K = 1'b0,
   parameter logic [7:0] CAL_BYTE   = 8'h80
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata_q,
   output logic             pready_q,
   output logic             pslverr_q,
   // CPU request
   input  wire logic        cpu_req,
   input  wire logic [2:0]  cpu_kind,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_we,
   input  wire logic [7:0]  cpu_wdata,
   // Security fuse level from outside the clock domain
   input  wire logic        security_lock,
   // Store side
   output logic             tgt_valid_q,
   output logic      [7:0]  tgt_sel_q,
   output logic      [15:0] tgt_addr_q,
   output logic             tgt_we_q,
   output logic      [7:0]  tgt_wdata_q,
   output logic      [7:0]  sig_rdata_q
);

   localparam logic [15:0] CODE_TOP  = VARIANT_8K ? `MSD_CODE_TOP_8K : `MSD_CODE_TOP_4K;
   localparam logic [15:0] FLASH_DATA_SPACE_TOP = VARIANT_8K ? `MSD_FLASH_DATA_SPACE_TOP_8K : `MSD_FLASH_DATA_SPACE_TOP_4K;

   logic [7:0]     ptr_cfg_q;
   logic [7:0]     mem_ctl_q;
   logic           page_q;
   logic [7:0]     sig_ptr_q;
   logic [7:0]     miss_cnt_q;
   logic [2:0]     lock_sync_q;
   logic           lock_q;
   msd_state_type  st_q;
   msd_target_type sel_d;
   logic [15:0]    addr_d;
   logic           we_d;
   logic           sig_sel;
   logic           in_app_program_select;
   logic           fde;
   logic           cpu_sig_use;
   logic           sig_wr;
   logic           apb_acc;
   logic           apb_sig_rd;
   logic           apb_wr;
   logic           addr_ok;
   logic           mem_en;
   logic [7:0]     mem_addr;
   logic [7:0]     mem_rdata;

   // Control bits taken from the configuration registers
   assign sig_sel = ptr_cfg_q[`MSD_SIG_SEL_BIT];
   assign in_app_program_select     = mem_ctl_q[`MSD_IAP_BIT];
   assign fde     = mem_ctl_q[`MSD_FDE_BIT];

   // Program space check, shared by fetch and code reads
   function automatic logic in_code(input logic [15:0] a);
      return a <= CODE_TOP;
   endfunction

   // User array window inside the signature space
   function automatic logic in_user(input logic [15:0] a);
      return (a <= `MSD_SIG_TOP) && (a[7:0] >= `MSD_USER_BASE);
   endfunction

   // Address decode; anything not listed lands on no store at all
   always_comb
   begin
      sel_d  = T_NONE;  // [RL7]
      addr_d = cpu_addr;
      unique case (cpu_kind)
         K_FETCH:
         begin
            if (in_code(cpu_addr))
            begin
               sel_d = T_CODE;  // [RL1] [RL6] [RL8]
            end
         end
         K_CODE_RD:
         begin
            if (sig_sel)
            begin
               // Gaps 40-7F and anything above 00FF are holes
               if (in_user(cpu_addr) ||
                   (cpu_addr <= `MSD_SIG_TOP && cpu_addr[7:0] <= `MSD_FACT_TOP))
               begin
                  sel_d = T_SIG;  // [RL10] [RL11] [RL16]
               end
            end
            else if (in_code(cpu_addr))
            begin
               sel_d = T_CODE;  // [RL9]
            end
         end
         K_DIRECT:
         begin
            sel_d  = cpu_addr[7] ? T_SFR : T_DRAM;  // [RL2] [RL4]
            addr_d = {8'h00, cpu_addr[7:0]};
         end
         K_INDIRECT:
         begin
            sel_d  = T_IRAM;  // [RL3]
            addr_d = {8'h00, cpu_addr[7:0]};
         end
         K_XMOVE_RI:
         begin
            sel_d  = T_XRAM;
            addr_d = {7'h00, page_q, cpu_addr[7:0]};  // [RL19]
         end
         K_XMOVE_PTR:
         begin
            if (in_app_program_select)
            begin
               if (sig_sel && in_user(cpu_addr))
               begin
                  sel_d = T_SIG;  // [RL12]
               end
            end
            else if (cpu_addr <= `MSD_XRAM_TOP)
            begin
               sel_d = T_XRAM;  // [RL5] [RL17]
            end
            else if (fde && cpu_addr <= FLASH_DATA_SPACE_TOP)
            begin
               sel_d = T_FLASH_DATA_SPACE;  // [RL18]
            end
         end
         default:
         begin
            sel_d = T_NONE;
         end
      endcase
   end

   // Signature port use; the lock never gates reads, only writes
   assign cpu_sig_use = cpu_req && (sel_d == T_SIG);
   assign sig_wr      = cpu_sig_use && cpu_we && (cpu_kind == K_XMOVE_PTR) && !lock_q;  // [RL15]
   // Code and missed stores never see a write strobe
   assign we_d        = cpu_req && cpu_we && (sel_d != T_NONE) && (sel_d != T_CODE) &&
                        ((sel_d != T_SIG) || sig_wr);  // [RL20]

   // Store-side outputs, one cycle after the request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tgt_valid_q <= 1'b0;
         tgt_sel_q   <= T_NONE;
         tgt_addr_q  <= 16'h0000;
         tgt_we_q    <= 1'b0;
         tgt_wdata_q <= 8'h00;
      end
      else
      begin
         tgt_valid_q <= cpu_req;
         tgt_sel_q   <= cpu_req ? sel_d : T_NONE;
         tgt_addr_q  <= addr_d;
         tgt_we_q    <= we_d;
         tgt_wdata_q <= cpu_wdata;
      end
   end

   // Security fuse: three stages, a change counts once stages two and three agree
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lock_sync_q <= 3'h0;
         lock_q      <= 1'b0;
      end
      else
      begin
         lock_sync_q <= {lock_sync_q[1:0], security_lock};
         if (lock_sync_q[1] == lock_sync_q[2])
         begin
            lock_q <= lock_sync_q[2];
         end
      end
   end

   // Signature port arbitration; the CPU always wins, APB reads just wait
   assign apb_acc    = psel && penable && !pready_q;
   assign apb_sig_rd = (st_q == ST_IDLE) && apb_acc && !pwrite &&
                       (paddr == `MSD_OFF_SIG_DATA) && !cpu_sig_use;
   assign mem_en     = cpu_sig_use || apb_sig_rd;
   assign mem_addr   = cpu_sig_use ? cpu_addr[7:0] : sig_ptr_q;

   msd_sig_mem #(
      .CAL_BYTE (CAL_BYTE)
   ) u_sig_mem (
      .clk     (clk),
      .rst     (rst),
      .en      (mem_en),
      .we      (sig_wr),
      .addr    (mem_addr),
      .wdata   (cpu_wdata),
      .rdata_q (mem_rdata)
   );  // [RL13]

   assign sig_rdata_q = mem_rdata;

   // Miss counter shows how often software touched unmapped space
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         miss_cnt_q <= 8'h00;
      end
      else if (cpu_req && sel_d == T_NONE)
      begin
         miss_cnt_q <= miss_cnt_q + 8'h01;
      end
   end

   // Known register offsets
   assign addr_ok = (paddr == `MSD_OFF_PTR_CFG) || (paddr == `MSD_OFF_MEM_CTL) ||
                    (paddr == `MSD_OFF_PAGE) || (paddr == `MSD_OFF_STATUS) ||
                    (paddr == `MSD_OFF_SIG_PTR) || (paddr == `MSD_OFF_SIG_DATA);
   // Writes land only on the completing edge of the access phase
   assign apb_wr  = psel && penable && pwrite && pready_q && !pslverr_q;

   // Configuration registers written by software
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ptr_cfg_q <= `MSD_PTR_CFG_RST;
         mem_ctl_q <= `MSD_MEM_CTL_RST;
         page_q    <= `MSD_PAGE_RST;
         sig_ptr_q <= `MSD_SIG_PTR_RST;
      end
      else if (apb_wr)
      begin
         if (paddr == `MSD_OFF_PTR_CFG)
         begin
            ptr_cfg_q <= pwdata[7:0];
         end
         if (paddr == `MSD_OFF_MEM_CTL)
         begin
            mem_ctl_q <= pwdata[7:0];
         end
         if (paddr == `MSD_OFF_PAGE)
         begin
            page_q <= pwdata[`MSD_PAGE_BIT];
         end
         if (paddr == `MSD_OFF_SIG_PTR)
         begin
            sig_ptr_q <= pwdata[7:0];
         end
      end
   end

   // APB answer sequencer; signature reads take one extra cycle for the array
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q      <= ST_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end
      else
      begin
         unique case (st_q)
            ST_IDLE:
            begin
               if (apb_sig_rd)
               begin
                  st_q <= ST_SIGRD;
               end
               else if (apb_acc && !(paddr == `MSD_OFF_SIG_DATA && !pwrite))
               begin
                  st_q      <= ST_ANS;
                  pready_q  <= 1'b1;
                  pslverr_q <= !addr_ok;
                  unique case (paddr)
                     `MSD_OFF_PTR_CFG: prdata_q <= {24'h000000, ptr_cfg_q};
                     `MSD_OFF_MEM_CTL: prdata_q <= {24'h000000, mem_ctl_q};
                     `MSD_OFF_PAGE:    prdata_q <= {31'h00000000, page_q};
                     `MSD_OFF_STATUS:  prdata_q <= {15'h0000, lock_q, miss_cnt_q, tgt_sel_q};
                     `MSD_OFF_SIG_PTR: prdata_q <= {24'h000000, sig_ptr_q};
                     default:          prdata_q <= 32'h00000000;
                  endcase
               end
            end
            ST_SIGRD:
            begin
               st_q     <= ST_ANS;
               pready_q <= 1'b1;
               prdata_q <= {24'h000000, mem_rdata};  // [RL15]
            end
            ST_ANS:
            begin
               st_q      <= ST_IDLE;
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sfr_route_a: assert property ( // [RL4]
      cpu_req && cpu_kind == K_DIRECT && cpu_addr[7] |=> tgt_sel_q == T_SFR)
      else $error("direct high address missed special registers");

   dram_route_a: assert property ( // [RL2]
      cpu_req && cpu_kind == K_DIRECT && !cpu_addr[7]
      |=> tgt_sel_q == T_DRAM && tgt_addr_q[15:7] == 9'h000)
      else $error("direct low address missed lower RAM");

   iram_route_a: assert property ( // [RL3]
      cpu_req && cpu_kind == K_INDIRECT |=> tgt_sel_q == T_IRAM)
      else $error("indirect access missed internal RAM");

   xram_low_a: assert property ( // [RL17]
      cpu_req && cpu_kind == K_XMOVE_PTR && !in_app_program_select && cpu_addr <= `MSD_XRAM_TOP
      |=> tgt_sel_q == T_XRAM)
      else $error("pointer move missed extra RAM");

   flash_data_space_gate_a: assert property ( // [RL18]
      cpu_req && !fde |=> tgt_sel_q != T_FLASH_DATA_SPACE)
      else $error("flash data reached while disabled");

   page_bit_a: assert property ( // [RL19]
      cpu_req && cpu_kind == K_XMOVE_RI |=> tgt_addr_q[8] == $past(page_q))
      else $error("page bit not applied");

   vector_code_a: assert property ( // [RL8]
      cpu_req && cpu_kind == K_FETCH && cpu_addr < `MSD_VECTOR_SPAN |=> tgt_sel_q == T_CODE)
      else $error("vector fetch missed program memory");

   sig_redirect_a: assert property ( // [RL10]
      cpu_req && cpu_kind == K_CODE_RD && sig_sel |=> tgt_sel_q != T_CODE)
      else $error("code read not redirected to signature");

   sig_lock_a: assert property ( // [RL15]
      lock_q && cpu_req && cpu_we && cpu_kind == K_XMOVE_PTR
      |=> !(tgt_we_q && tgt_sel_q == T_SIG))
      else $error("signature written while locked");

   miss_quiet_a: assert property ( // [RL20]
      tgt_sel_q == T_NONE |-> !tgt_we_q)
      else $error("write strobe on unmapped access");

   apb_answer_a: assert property (
      psel && penable && !pready_q && !cpu_req |-> ##[1:3] pready_q)
      else $error("APB answer late");

endmodule

/* msd_cpu_model.sv */
// CPU core stand-in on the decoder's request side.
// Assumes one caller process; each access takes two clock cycles.
`timescale 1ns/1ns

module msd_cpu_model
(
   input  wire logic        clk,
   output logic             cpu_req,
   output logic      [2:0]  cpu_kind,
   output logic      [15:0] cpu_addr,
   output logic             cpu_we,
   output logic      [7:0]  cpu_wdata
);
   // Idle at time zero
   initial
   begin
      cpu_req   = 1'b0;
      cpu_kind  = 3'h0;
      cpu_addr  = 16'h0000;
      cpu_we    = 1'b0;
      cpu_wdata = 8'h00;
   end

   // One access: raised after an edge, dropped after the taking edge
   task automatic access(input logic [2:0] k, input logic [15:0] a,
                         input logic w, input logic [7:0] d);
      @(posedge clk);
      cpu_req   <= 1'b1;
      cpu_kind  <= k;
      cpu_addr  <= a;
      cpu_we    <= w;
      cpu_wdata <= d;
      @(posedge clk);
      cpu_req   <= 1'b0;
      cpu_we    <= 1'b0;
      // Released lines flip so a stale value never matches by luck
      cpu_addr  <= ~a;
      cpu_wdata <= ~d;
   endtask
endmodule

/* testbench.sv */
// Self-checking bench for the memory space decoder, 4K layout.
// Assumes the CPU stand-in model and an APB master task below.
`timescale 1ns/1ns

module testbench;
   import msd_pkg::*;
   logic        clk, rst, psel, penable, pwrite, security_lock;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata_q;
   logic        pready_q, pslverr_q, cpu_req, cpu_we, tgt_valid_q, tgt_we_q;
   logic [2:0]  cpu_kind;
   logic [15:0] cpu_addr, tgt_addr_q;
   logic [7:0]  cpu_wdata, tgt_sel_q, tgt_wdata_q, sig_rdata_q;
   int          n_errors, cmp_count, cyc, sig_sel, in_app_program_select, fde, page, lock_m, miss;
   int unsigned seed = 80365;
   logic [7:0]  sig_m [256];
   int          lst_a[] = '{'h0052, 'h0fff, 'h1000, 'h2007f, 'h20080, 'h3007f,
                            'h501ff, 'h50200, 'h503ff, 'h50400, 'h400ff};
   int          lst_s[] = '{'h10000, 'h10001, 'h1003f, 'h10040, 'h100c0, 'h10100};

   msd_decoder msd_decoder_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .cpu_req(cpu_req),
      .cpu_kind(cpu_kind), .cpu_addr(cpu_addr), .cpu_we(cpu_we),
      .cpu_wdata(cpu_wdata), .security_lock(security_lock),
      .tgt_valid_q(tgt_valid_q), .tgt_sel_q(tgt_sel_q), .tgt_addr_q(tgt_addr_q),
      .tgt_we_q(tgt_we_q), .tgt_wdata_q(tgt_wdata_q), .sig_rdata_q(sig_rdata_q));
   msd_cpu_model msd_cpu_model_inst (.clk(clk), .cpu_req(cpu_req), .cpu_kind(cpu_kind),
      .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_wdata(cpu_wdata));

   // 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         end_sim();
      end
   end

   function automatic int unsigned nxt();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   // APB master: holds the request until pready is seen at an edge
   task automatic apb(input int wr, input int a, input int wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr[0];
      paddr   <= a[7:0];
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready_q !== 1'b1)
      begin
         n++;
         @(posedge clk);
      end
      // Signature data reads wait one cycle more for the array
      chk("apb_wait", (a == 'h14 && !wr) ? 2 : 1, n);
      rd = prdata_q;
      err = pslverr_q;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_cfg(input int s, input int i, input int f, input int p);
      logic [31:0] rd;
      logic        e;
      sig_sel = s;
      in_app_program_select = i;
      fde = f;
      page = p;
      apb(1, 'h00, s << 3, rd, e);
      apb(1, 'h04, (i << 7) | (f << 3), rd, e);
      apb(1, 'h08, p, rd, e);
      apb(0, 'h04, 0, rd, e);
      chk("mem_ctl", (i << 7) | (f << 3), rd);
   endtask

   // Programmer path read of the signature array, never locked out
   task automatic sig_rd(input int a);
      logic [31:0] rd;
      logic        e;
      apb(1, 'h10, a, rd, e);
      apb(0, 'h14, 0, rd, e);
      chk("sig_data", sig_m[a], rd);
   endtask

   // Reference decode worked out from the address map
   task automatic do_acc(input int k, input int a, input int w, input int d);
      int sel, ta, we_e;
      sel = T_NONE;
      ta = a;
      if (k == 0 && a <= 'h0fff) sel = T_CODE;
      if (k == 1 && !sig_sel && a <= 'h0fff) sel = T_CODE;
      if (k == 1 && sig_sel && (a <= 'h3f || (a >= 'h80 && a <= 'hff)))
         sel = T_SIG;
      if (k == 2) sel = (a < 'h80) ? T_DRAM : T_SFR;
      if (k == 3) sel = T_IRAM;
      if (k == 4) sel = T_XRAM;
      if (k == 4) ta = page * 256 + a;
      if (k == 5 && in_app_program_select && sig_sel) sel = T_SIG;
      if (k == 5 && !in_app_program_select && a <= 'h1ff) sel = T_XRAM;
      if (k == 5 && !in_app_program_select && fde && a >= 'h200 && a <= 'h3ff) sel = T_FLASH_DATA_SPACE;
      we_e = w && sel != T_NONE && sel != T_CODE && !(sel == T_SIG && lock_m);
      if (sel == T_NONE) miss++;
      msd_cpu_model_inst.access(k[2:0], a[15:0], w[0], d[7:0]);
      #1;
      chk("tgt_valid", 1, tgt_valid_q);
      chk("tgt_sel", sel, tgt_sel_q);
      if (sel != T_NONE) chk("tgt_addr", ta, tgt_addr_q);
      chk("tgt_we", we_e, tgt_we_q);
      if (we_e) chk("tgt_wdata", d, tgt_wdata_q);
      if (sel == T_SIG && !w) chk("sig_rdata", sig_m[a], sig_rdata_q);
      if (we_e && sel == T_SIG) sig_m[a] = d;
   endtask

   task automatic run_list(input int q[]);
      foreach (q[i])
         do_acc(q[i] >> 16, q[i] & 'hffff, 0, 0);
   endtask

   task automatic rand_run(input int n);
      int unsigned r;
      int          k, a;
      for (int i = 0; i < n; i++)
      begin
         r = nxt();
         if (i % 8 == 0)
            set_cfg(r[8], r[8] & r[9], r[10], r[11]);
         k = r % 8;
         a = (k < 2) ? r[28:16] : (k < 5) ? r[23:16] : in_app_program_select ? 'h80 | r[22:16] : r[26:16];
         do_acc(k, a, (k > 1) ? r[30] : 0, r[7:0]);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      logic [31:0] rd;
      logic        e;
      {psel, penable, pwrite, security_lock} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      foreach (sig_m[i])
         sig_m[i] = 8'hff;
      sig_m[0] = 8'h5a;
      sig_m[1] = 8'h3c;
      sig_m['hc0] = 8'h80;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      foreach (lst_s[i])
      begin
         apb(0, i * 4, 0, rd, e);
         chk("reset_val", (i == 3) ? int'(T_NONE) : (i == 5) ? int'(sig_m[0]) : 0, rd);
      end
      apb(0, 'h18, 0, rd, e);
      chk("unmapped_err", 1, e);
      sig_rd(0);
      sig_rd('hc0);
      $display("test registers done");
      set_cfg(0, 0, 1, 0);
      run_list(lst_a);
      set_cfg(0, 0, 0, 1);
      run_list(lst_a);
      set_cfg(1, 0, 0, 0);
      run_list(lst_s);
      set_cfg(1, 1, 0, 0);
      do_acc(5, 'h85, 1, 'ha7);
      do_acc(1, 'h85, 0, 0);
      set_cfg(0, 0, 0, 0);
      do_acc(1, 'h0fff, 0, 0);
      $display("test directed done");
      rand_run(48);
      $display("test random done");
      @(posedge clk);
      security_lock <= 1'b1;
      repeat (6) @(posedge clk);
      lock_m = 1;
      rand_run(24);
      set_cfg(1, 1, 0, 0);
      do_acc(5, 'h85, 1, 'h11);
      sig_rd('h85);
      apb(0, 'h0c, 0, rd, e);
      chk("status", (lock_m << 16) | ((miss & 'hff) << 8) | int'(T_NONE), rd);
      $display("test locked done");
      end_sim();
   end
endmodule
